// [hdl/cvt_params.svh]
// constants for the channel validation trigger select block
`ifndef CVT_PARAMS_SVH
`define CVT_PARAMS_SVH
// register byte offsets
`define CVT_OFS_SEL_A        12'h000
`define CVT_OFS_SEL_B        12'h004
`define CVT_OFS_STRETCH      12'h008
`define CVT_OFS_FT_SHAPE     12'h00C
`define CVT_OFS_VAL_REQ      12'h010
`define CVT_OFS_MASK_BASE    12'h040
`define CVT_OFS_STATUS       12'h080
`define CVT_OFS_EVENT        12'h084
// field positions
`define CVT_MASK_MULT_BIT    16
`define CVT_MASK_GROUP_BIT   31
`define CVT_SELB_CHOICE_LSB  16
`define CVT_SELB_GATED_LSB   24
`define CVT_SELB_CHAN_LSB    28
// reset values
`define CVT_SEL_RESET        32'h0000_0000
`define CVT_STRETCH_RESET    8'h01
`define CVT_FT_LEN_RESET     8'h01
`define CVT_FT_DLY_RESET     8'h00
`endif

// [hdl/cvt_pkg.sv]
// types shared by the trigger select block
package cvt_pkg;
    // group candidate choice codes
    typedef enum logic [1:0]
    {
        GRP_LOCAL = 2'h0,
        GRP_RIGHT = 2'h1,
        GRP_LEFT  = 2'h2,
        GRP_OFF   = 2'h3
    } grp_choice_t;
endpackage : cvt_pkg

// [hdl/ft_shaper.sv]
// delays and re-widths one local fast trigger
`timescale 1ns/1ns
`default_nettype none
module ft_shaper
#(
    parameter int CW = 8
)
(
    // clock and reset
    input  wire logic          clk,
    input  wire logic          resetn,
    // settings
    input  wire logic [CW-1:0] delay_cycles,
    input  wire logic [CW-1:0] length_cycles,
    // trigger in and out
    input  wire logic          trig_in,
    output logic               trig_out
);
    typedef struct packed
    {
        logic          prev;   // last input level
        logic [CW-1:0] dcnt;   // delay countdown
        logic          dact;   // delay running
        logic [CW-1:0] wcnt;   // width countdown
        logic          out;    // shaped output
    } st_t;
    st_t s_reg;
    st_t s_next;
    // rising edge starts delay, then output held length cycles
    always_comb
    begin
        s_next = s_reg;
        s_next.prev = trig_in;
        if (trig_in && !s_reg.prev && !s_reg.dact)
        begin
            s_next.dact = 1'b1;
            s_next.dcnt = delay_cycles;
        end
        else if (s_reg.dact)
        begin
            if (s_reg.dcnt == '0)
            begin
                s_next.dact = 1'b0;
                s_next.wcnt = length_cycles;
            end
            else
                s_next.dcnt = s_reg.dcnt - 1'b1;
        end
        if (s_reg.wcnt != '0 && !(s_reg.dact && s_reg.dcnt == '0))
            s_next.wcnt = s_reg.wcnt - 1'b1;
        s_next.out = (s_next.wcnt != '0);
    end
    // state register
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            s_reg <= '0;
        else
            s_reg <= s_next;
    end
    assign trig_out = s_reg.out;
endmodule : ft_shaper
`default_nettype wire

// [hdl/val_stretch.sv]
// catches a validation edge as a pulse and stretches it
`timescale 1ns/1ns
`default_nettype none
module val_stretch
#(
    parameter int CW = 8
)
(
    // clock and reset
    input  wire logic          clk,
    input  wire logic          resetn,
    // stretch length in cycles
    input  wire logic [CW-1:0] stretch_len,
    // trigger in, stretched out
    input  wire logic          trig_in,
    output logic               pulse,
    output logic               stretched
);
    typedef struct packed
    {
        logic          prev;   // last input level
        logic          pls;    // one-cycle capture
        logic [CW-1:0] cnt;    // stretch countdown
    } st_t;
    st_t s_reg;
    st_t s_next;
    // edge to single pulse, pulse reloads the stretch counter
    always_comb
    begin
        s_next = s_reg;
        s_next.prev = trig_in;
        s_next.pls = trig_in && !s_reg.prev;
        if (s_reg.pls)
            s_next.cnt = stretch_len;
        else if (s_reg.cnt != '0)
            s_next.cnt = s_reg.cnt - 1'b1;
    end
    // state register
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
            s_reg <= '0;
        else
            s_reg <= s_next;
    end
    assign pulse = s_reg.pls;
    assign stretched = (s_reg.cnt != '0);
endmodule : val_stretch
`default_nettype wire

// [hdl/channel_validation_trigger_select.sv]
// trigger routing: group, gated and channel validation triggers
//
// What this block does
// - group 0 candidates from select A 11..0
// - group 1 candidates from select A 23..12
// - group 2 candidates: A 31..24, B 3..0
// - group 3 candidates from select B 15..4
// - two-bit choice per group, B 23..16
// - channels 0-3 group 0 or gated, B24
// - same with B25, B26, B27 per quad
// - channel trigger output indexed by B 31..28
// - gated trigger is local AND external
// - local triggers shaped by length and delay
// - mask bit 16 picks multiplicity or coincidence
// - mask bit 31 picks group-gated or mult-coinc
// - validation captured as pulse, then stretched
// - validation required gates event recording
//
// Local design decisions: the APB register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none
`include "cvt_params.svh"
module channel_validation_trigger_select
#(
    parameter int NCH = 16,
    parameter int CW  = 8
)
(
    // clock and reset
    input  wire logic            clk,
    input  wire logic            resetn,
    // apb slave
    input  wire logic            psel,
    input  wire logic            penable,
    input  wire logic            pwrite,
    input  wire logic [11:0]     paddr,
    input  wire logic [31:0]     pwdata,
    output logic      [31:0]     prdata,
    output logic                 pready,
    output logic                 pslverr,
    // trigger sources, asynchronous pins
    input  wire logic [NCH-1:0]  local_channel_fast_trigger,
    input  wire logic [NCH-1:0]  right_fast_trigger,
    input  wire logic [NCH-1:0]  left_fast_trigger,
    input  wire logic            ext_fast_trigger,
    input  wire logic [NCH-1:0]  mult_trigger,
    input  wire logic [NCH-1:0]  coinc_trigger,
    // outputs
    output logic [3:0]           group_trigger,
    output logic [NCH-1:0]       validation_trigger,
    output logic                 channel_trigger,
    output logic [NCH-1:0]       event_record
);
    // all registered state of this module apart from the synchronisers, shapers and stretchers
    // one struct, filled by the decode process below
    typedef struct packed
    {
        logic [31:0]          sel_a;      // group_candidate_select_a
        logic [31:0]          sel_b;      // group_candidate_select_b
        logic [CW-1:0]        stretch;    // channel trigger stretch length
        logic [CW-1:0]        ft_len;     // backplane pulse length
        logic [CW-1:0]        ft_dly;     // backplane delay
        logic [NCH-1:0]       val_req;    // validation_required_bit per channel
        logic [NCH-1:0][31:0] mask_hi;    // upper_contribution_mask per channel
        logic [NCH-1:0]       evt_seen;   // sticky recorded events
        logic [3:0]           grp;        // group trigger outputs
        logic [NCH-1:0]       val;        // validation outputs
        logic                 chan;       // selected channel trigger
        logic [NCH-1:0]       evt;        // event record pulses
        logic [31:0]          rdata;      // read data
        logic                 rdy;        // apb ready
        logic                 err;        // apb error
    } st_t;
    st_t s_reg;
    st_t s_next;

    // two-stage synchronisers for every pin input
    // pins are not timed to clk, so each passes two flops
    // only the second stage feeds any logic
    logic [5*NCH:0] sync1_reg;
    logic [5*NCH:0] sync2_reg;
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            sync1_reg <= '0;
            sync2_reg <= '0;
        end
        else
        begin
            sync1_reg <= {ext_fast_trigger, coinc_trigger, mult_trigger,
                          left_fast_trigger, right_fast_trigger,
                          local_channel_fast_trigger};
            sync2_reg <= sync1_reg;
        end
    end
    // second stage split back into its sources
    logic [NCH-1:0] loc_s;    // synchronised local triggers
    logic [NCH-1:0] rgt_s;    // right neighbour
    logic [NCH-1:0] lft_s;    // left neighbour
    logic [NCH-1:0] mul_s;    // multiplicity
    logic [NCH-1:0] coi_s;    // coincidence
    logic           ext_s;    // external fast trigger
    assign loc_s = sync2_reg[NCH-1:0];
    assign rgt_s = sync2_reg[2*NCH-1:NCH];
    assign lft_s = sync2_reg[3*NCH-1:2*NCH];
    assign mul_s = sync2_reg[4*NCH-1:3*NCH];
    assign coi_s = sync2_reg[5*NCH-1:4*NCH];
    assign ext_s = sync2_reg[5*NCH];

    // pick one of sixteen lines by a 4-bit index
    // index is four bits wide, so NCH stays at sixteen
    function automatic logic pick16(input logic [NCH-1:0] v, input logic [3:0] i);
        pick16 = v[i];
    endfunction : pick16

    // choice decode
    // code 3, and any unknown code, keeps the group quiet
    function automatic logic choose(input logic [1:0] c, input logic l,
                                    input logic r, input logic f);
        case (cvt_pkg::grp_choice_t'(c))
            cvt_pkg::GRP_LOCAL: choose = l;
            cvt_pkg::GRP_RIGHT: choose = r;
            cvt_pkg::GRP_LEFT:  choose = f;
            default:            choose = 1'b0;
        endcase
    endfunction : choose

    // per-channel shapers for pulse width and delay
    // one length and one delay shared by all channels
    // a new edge during a running delay is ignored
    logic [NCH-1:0] shaped;   // shaped local fast triggers
    logic [NCH-1:0] pls;      // captured pulses
    logic [NCH-1:0] str;      // stretched validation
    for (genvar c = 0; c < NCH; c++)
    begin : g_ch
        ft_shaper #(.CW(CW)) u_shape
        (
            .clk           (clk),
            .resetn        (resetn),
            .delay_cycles  (s_reg.ft_dly),
            .length_cycles (s_reg.ft_len),
            .trig_in       (loc_s[c]),
            .trig_out      (shaped[c])
        );
        // capture and stretch
        // stretcher watches the registered validation level
        val_stretch #(.CW(CW)) u_str
        (
            .clk         (clk),
            .resetn      (resetn),
            .stretch_len (s_reg.stretch),
            .trig_in     (s_reg.val[c]),
            .pulse       (pls[c]),
            .stretched   (str[c])
        );
    end

    // candidate and trigger routing
    // local candidates are taken after the shaper
    // neighbour lines are used straight from the synchroniser
    logic [3:0]     cand_l;   // local candidates
    logic [3:0]     cand_r;   // right candidates
    logic [3:0]     cand_f;   // left candidates
    logic [3:0]     grp_c;    // group triggers
    logic [NCH-1:0] gated;    // gated local triggers
    logic [NCH-1:0] val_c;    // validation triggers
    always_comb
    begin
        cand_l[0] = pick16(shaped, s_reg.sel_a[3:0]);
        cand_r[0] = pick16(rgt_s, s_reg.sel_a[7:4]);
        cand_f[0] = pick16(lft_s, s_reg.sel_a[11:8]);
        cand_l[1] = pick16(shaped, s_reg.sel_a[15:12]);
        cand_r[1] = pick16(rgt_s, s_reg.sel_a[19:16]);
        cand_f[1] = pick16(lft_s, s_reg.sel_a[23:20]);
        cand_l[2] = pick16(shaped, s_reg.sel_a[27:24]);
        cand_r[2] = pick16(rgt_s, s_reg.sel_a[31:28]);
        cand_f[2] = pick16(lft_s, s_reg.sel_b[3:0]);
        cand_l[3] = pick16(shaped, s_reg.sel_b[7:4]);
        cand_r[3] = pick16(rgt_s, s_reg.sel_b[11:8]);
        cand_f[3] = pick16(lft_s, s_reg.sel_b[15:12]);
        // final group choice
        // code 3 turns the group off
        for (int g = 0; g < 4; g++)
            grp_c[g] = choose(s_reg.sel_b[`CVT_SELB_CHOICE_LSB+2*g +: 2],
                              cand_l[g], cand_r[g], cand_f[g]);
        for (int c = 0; c < NCH; c++)
        begin
            gated[c] = shaped[c] & ext_s;
            // final source, group or gated, mult or coinc
            if (s_reg.mask_hi[c][`CVT_MASK_GROUP_BIT])
                val_c[c] = s_reg.sel_b[`CVT_SELB_GATED_LSB + c/4] ? grp_c[c/4] : gated[c];
            else
                val_c[c] = s_reg.mask_hi[c][`CVT_MASK_MULT_BIT] ? mul_s[c] : coi_s[c];
        end
    end

    // apb decode, register writes and outputs
    // one wait state: ready follows the first access-phase edge
    // a write lands on that first access-phase edge
    // ready, read data and error stand for one cycle only
    logic       wr_en;    // write access phase
    logic       rd_en;    // read access phase
    logic [3:0] midx;     // mask register index
    logic       in_mask;  // address in mask block
    always_comb
    begin
        s_next = s_reg;
        wr_en = psel && penable && pwrite && !s_reg.rdy;
        rd_en = psel && penable && !pwrite && !s_reg.rdy;
        midx = paddr[5:2];
        // mask block holds one aligned word per channel
        in_mask = (paddr[11:6] == 6'(`CVT_OFS_MASK_BASE >> 6));
        s_next.rdy = psel && penable && !s_reg.rdy;
        s_next.err = 1'b0;
        s_next.rdata = '0;
        if (wr_en)
        begin
            if (in_mask && paddr[1:0] == 2'h0)
                s_next.mask_hi[midx] = pwdata;
            else
                case (paddr)
                    `CVT_OFS_SEL_A:    s_next.sel_a = pwdata;
                    `CVT_OFS_SEL_B:    s_next.sel_b = pwdata;
                    `CVT_OFS_STRETCH:  s_next.stretch = pwdata[CW-1:0];
                    `CVT_OFS_FT_SHAPE:
                    begin
                        s_next.ft_len = pwdata[CW-1:0];
                        s_next.ft_dly = pwdata[CW+15:16];
                    end
                    `CVT_OFS_VAL_REQ:  s_next.val_req = pwdata[NCH-1:0];
                    // event flags are cleared further down
                    `CVT_OFS_EVENT:    ;
                    // status is read-only: a write to it is refused
                    default:           s_next.err = 1'b1;
                endcase
        end
        // unmapped reads return zero with the error flag
        if (rd_en)
        begin
            if (in_mask && paddr[1:0] == 2'h0)
                s_next.rdata = s_reg.mask_hi[midx];
            else
                case (paddr)
                    `CVT_OFS_SEL_A:    s_next.rdata = s_reg.sel_a;
                    `CVT_OFS_SEL_B:    s_next.rdata = s_reg.sel_b;
                    `CVT_OFS_STRETCH:  s_next.rdata = 32'(s_reg.stretch);
                    `CVT_OFS_FT_SHAPE: s_next.rdata = {8'h00, s_reg.ft_dly, 8'h00, s_reg.ft_len};
                    `CVT_OFS_VAL_REQ:  s_next.rdata = 32'(s_reg.val_req);
                    `CVT_OFS_STATUS:   s_next.rdata = {12'h000, s_reg.grp, s_reg.val};
                    `CVT_OFS_EVENT:    s_next.rdata = 32'(s_reg.evt_seen);
                    default:           s_next.err = 1'b1;
                endcase
        end
        s_next.grp = grp_c;
        s_next.val = val_c;
        s_next.chan = pick16(val_c, s_reg.sel_b[`CVT_SELB_CHAN_LSB +: 4]);
        // validation overlap qualifies recording
        // without the requirement every shaped trigger counts
        for (int c = 0; c < NCH; c++)
            s_next.evt[c] = shaped[c] && !s_reg.val_req[c] ? 1'b1 :
                            shaped[c] && (str[c] || pls[c]);
        // sticky event flags: write-one clears, new event wins
        if (wr_en && paddr == `CVT_OFS_EVENT)
            s_next.evt_seen = s_reg.evt_seen & ~pwdata[NCH-1:0];
        s_next.evt_seen = s_next.evt_seen | s_reg.evt;
    end

    // state register
    // configuration loads its reset values, the rest clears
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            s_reg <= '0;
            s_reg.sel_a <= `CVT_SEL_RESET;
            s_reg.sel_b <= `CVT_SEL_RESET;
            s_reg.stretch <= `CVT_STRETCH_RESET;
            s_reg.ft_len <= `CVT_FT_LEN_RESET;
            s_reg.ft_dly <= `CVT_FT_DLY_RESET;
        end
        else
            s_reg <= s_next;
    end

    // outputs from flip-flops
    // no logic after the flops, so outputs never glitch
    assign prdata = s_reg.rdata;
    assign pready = s_reg.rdy;
    assign pslverr = s_reg.err;
    assign group_trigger = s_reg.grp;
    assign validation_trigger = s_reg.val;
    assign channel_trigger = s_reg.chan;
    assign event_record = s_reg.evt;
endmodule : channel_validation_trigger_select
`default_nettype wire

// [verif/cvt_monitor.sv]
// port checker for the trigger select block
`timescale 1ns/1ns
`default_nettype none
module cvt_monitor
#(
    parameter int NCH = 16
)
(
    // clock and reset
    input wire logic           clk,
    input wire logic           resetn,
    // apb
    input wire logic           psel,
    input wire logic           penable,
    input wire logic           pwrite,
    input wire logic [11:0]    paddr,
    input wire logic [31:0]    pwdata,
    input wire logic [31:0]    prdata,
    input wire logic           pready,
    input wire logic           pslverr,
    // triggers
    input wire logic [3:0]     group_trigger,
    input wire logic [NCH-1:0] validation_trigger,
    input wire logic           channel_trigger
);
    logic [31:0]    selb_reg; // copy of select b
    logic [NCH-1:0] val_reg;  // last validation
    logic [2:0]     age_reg;  // steady cycles
    logic [3:0]     off_w;    // groups set off
    // mapped word addresses
    function automatic logic mapped(input logic [11:0] a);
        return a inside {12'h000, 12'h004, 12'h008, 12'h00C, 12'h010, 12'h080, 12'h084}
            || (a inside {[12'h040:12'h07C]} && a[1:0] == 2'h0);
    endfunction : mapped
    // copy select b, count cycles of a steady setup
    always_ff @(posedge clk or negedge resetn)
    begin
        if (!resetn)
        begin
            selb_reg <= 32'h0000_0000;
            val_reg  <= '0;
            age_reg  <= 3'h0;
        end
        else
        begin
            val_reg <= validation_trigger;
            // write takes effect with ready
            if (psel && penable && pready && pwrite && paddr == 12'h004)
                selb_reg <= pwdata;
            // any write or validation change restarts the count
            if ((psel && pwrite) || validation_trigger != val_reg)
                age_reg <= 3'h0;
            else if (age_reg != 3'h7)
                age_reg <= age_reg + 3'h1;
        end
    end
    assign off_w = {&selb_reg[23:22], &selb_reg[21:20], &selb_reg[19:18], &selb_reg[17:16]};
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);
    sequence access_wait; psel && penable && !pready; endsequence
    sequence ready_beat; ##1 pready; endsequence
    pready_pulse_a: assert property (pready |=> !pready)
        else $error("ready held two cycles");
    pready_cause_a: assert property (pready |-> $past(psel) && $past(penable))
        else $error("ready without access");
    answer_bound_a: assert property (access_wait |-> ready_beat)
        else $error("access not answered in one cycle");
    err_ready_a: assert property (pslverr |-> pready)
        else $error("error flag without ready");
    err_decode_a: assert property (pready
        |-> pslverr == !(mapped(paddr) && !(pwrite && paddr == 12'h080)))
        else $error("error flag does not match address");
    err_data_a: assert property (pslverr |-> prdata == 32'h0000_0000)
        else $error("refused access returned data");
    idle_data_a: assert property (!pready |-> prdata == 32'h0000_0000)
        else $error("read data outside ready");
    chan_pick_a: assert property (age_reg >= 3'h3
        |-> channel_trigger == validation_trigger[selb_reg[31:28]])
        else $error("channel trigger not the indexed one");
    group_off_a: assert property (age_reg >= 3'h3 |-> (group_trigger & off_w) == 4'h0)
        else $error("group set off is high");
endmodule : cvt_monitor
bind channel_validation_trigger_select cvt_monitor #(.NCH(NCH)) cvt_monitor_inst
(
    .clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .group_trigger, .validation_trigger, .channel_trigger
);
`default_nettype wire

// [verif/neighbour_ft_model.sv]
// fast trigger lines from both neighbouring modules
`timescale 1ns/1ns
`default_nettype none
module neighbour_ft_model
(
    // clock
    input wire logic    clk,
    // lines towards this module
    output logic [15:0] right_fast_trigger,
    output logic [15:0] left_fast_trigger
);
    // lines low until a neighbour fires
    initial
    begin
        right_fast_trigger = 16'h0000;
        left_fast_trigger  = 16'h0000;
    end
    // change both sides just after an edge
    task automatic drive(input logic [15:0] r, input logic [15:0] l);
        @(posedge clk);
        right_fast_trigger <= r;
        left_fast_trigger  <= l;
    endtask : drive
endmodule : neighbour_ft_model
`default_nettype wire

// [verif/tb_channel_validation_trigger_select.sv]
// self-checking bench for the trigger select block
`timescale 1ns/1ns
`default_nettype none
module tb_channel_validation_trigger_select;
    logic        clk, resetn, psel, penable, pwrite, pready, pslverr, er;
    logic        ext_fast_trigger, channel_trigger;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, sb;
    logic [15:0] local_channel_fast_trigger, right_fast_trigger, left_fast_trigger, r1, l1;
    logic [15:0] mult_trigger, coinc_trigger, validation_trigger, event_record;
    logic [3:0]  group_trigger, eg;
    int          miscompares = 0, n_compared = 0, cycles = 0;
    int          ridx[4] = '{5, 6, 14, 12}; // right index per group
    int          lidx[4] = '{9, 10, 7, 15}; // left index per group
    logic [11:0] ra[9] = '{12'h000, 12'h004, 12'h008, 12'h00C, 12'h010,
                           12'h040, 12'h080, 12'h0FC, 12'h041}; // last two unmapped
    channel_validation_trigger_select #(.NCH(16), .CW(8)) channel_validation_trigger_select_inst
    (
        .clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .local_channel_fast_trigger, .right_fast_trigger, .left_fast_trigger, .ext_fast_trigger,
        .mult_trigger, .coinc_trigger, .group_trigger, .validation_trigger, .channel_trigger,
        .event_record
    );
    neighbour_ft_model neighbour_ft_model_inst (.clk, .right_fast_trigger, .left_fast_trigger);
    // 50 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // cycle ceiling cuts a hang short
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 20000)
        begin
            miscompares++;
            complete_run();
        end
    end
    // counts, verdict, end
    task automatic complete_run();
        $display("compared %0d, wrong %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : complete_run
    // one comparison
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_compared++;
        if (got !== exp)
        begin
            miscompares++;
            $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask : chk
    // apb transfer held until ready
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask : wr
    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp, input logic err);
        apb(1'b0, a, 32'h0000_0000);
        chk(rd, exp, "read data");
        chk({31'h0, er}, {31'h0, err}, "error flag");
    endtask : rdchk
    // settle then compare trigger outputs
    task automatic tchk(input logic [3:0] g, input logic [15:0] v);
        repeat (8) @(posedge clk);
        chk({28'h0, group_trigger}, {28'h0, g}, "group");
        chk({16'h0, validation_trigger}, {16'h0, v}, "validation");
    endtask : tchk
    initial
    begin
        resetn = 1'b0;
        {psel, penable, pwrite, ext_fast_trigger} = 4'h0;
        paddr  = 12'h000;
        pwdata = 32'h0000_0000;
        {local_channel_fast_trigger, mult_trigger, coinc_trigger} = 48'h0;
        repeat (2) @(posedge clk);
        chk({12'h000, group_trigger, validation_trigger}, 32'h0000_0000, "reset outputs");
        chk({15'h0, channel_trigger, event_record}, 32'h0000_0000, "reset outputs");
        resetn <= 1'b1;
        // reset values and refused places
        for (int i = 0; i < 9; i++)
            rdchk(ra[i], (i == 2 || i == 3) ? 32'h0000_0001 : 32'h0000_0000, i > 6);
        // neighbour candidates, choice codes 1 to 3 (right, left, off)
        wr(12'h000, 32'hE1A6_2953);
        for (int g = 0; g < 4; g++)
            for (int c = 1; c < 4; c++)
            begin
                sb = 32'h00FF_FC47;
                sb[16 + 2 * g +: 2] = c[1:0];
                wr(12'h004, sb);
                r1 = 16'h0001 << ridx[g];
                l1 = 16'h0001 << lidx[g];
                eg = (c == 3) ? 4'h0 : 4'h1 << g;
                neighbour_ft_model_inst.drive(c == 2 ? ~r1 : r1, c == 1 ? ~l1 : l1);
                tchk(eg, 16'h0000);
                rdchk(12'h080, {12'h000, eg, 16'h0000}, 1'b0);
                neighbour_ft_model_inst.drive(~r1, ~l1);
                tchk(4'h0, 16'h0000);
            end
        // local candidates, gated triggers, shaping
        wr(12'h00C, 32'h0002_0020);
        for (int c = 0; c < 16; c++)
            wr(12'h040 + 12'(4 * c), 32'h8000_0000);
        wr(12'h004, 32'h4500_FC47);
        ext_fast_trigger <= 1'b1;
        local_channel_fast_trigger <= 16'h001E;
        repeat (6) @(posedge clk);
        chk({16'h0, validation_trigger}, 32'h0000_0000, "delayed validation");
        tchk(4'hF, 16'h0F1F);
        chk({31'h0, channel_trigger}, 32'h0000_0001, "channel trigger");
        local_channel_fast_trigger <= 16'h0000;
        repeat (40) @(posedge clk);
        local_channel_fast_trigger <= 16'hFFE1;
        tchk(4'h0, 16'hF0E0);
        repeat (40) @(posedge clk);
        tchk(4'h0, 16'h0000);
        local_channel_fast_trigger <= 16'h0000;
        ext_fast_trigger <= 1'b0;
        repeat (8) @(posedge clk);
        local_channel_fast_trigger <= 16'hFFFF;
        tchk(4'hF, 16'h0F0F);
        local_channel_fast_trigger <= 16'h0000;
        // multiplicity against coincidence
        for (int c = 0; c < 16; c++)
            wr(12'h040 + 12'(4 * c), c[0] ? 32'h0001_0000 : 32'h0000_0000);
        mult_trigger <= 16'hFFFF;
        tchk(4'h0, 16'hAAAA);
        mult_trigger  <= 16'h0000;
        coinc_trigger <= 16'hFFFF;
        tchk(4'h0, 16'h5555);
        coinc_trigger <= 16'h0000;
        // stretch long enough to overlap
        wr(12'h008, 32'h0000_00FF);
        wr(12'h010, 32'h0000_0001);
        wr(12'h084, 32'hFFFF_FFFF);
        coinc_trigger <= 16'h0001;
        repeat (4) @(posedge clk);
        local_channel_fast_trigger <= 16'h0003;
        repeat (20) @(posedge clk);
        chk({16'h0, event_record}, 32'h0000_0003, "event record");
        rdchk(12'h084, 32'h0000_0003, 1'b0);
        local_channel_fast_trigger <= 16'h0000;
        repeat (40) @(posedge clk);
        wr(12'h084, 32'hFFFF_FFFF);
        repeat (300) @(posedge clk);
        local_channel_fast_trigger <= 16'h0003;
        repeat (20) @(posedge clk);
        chk({16'h0, event_record}, 32'h0000_0002, "event record");
        rdchk(12'h084, 32'h0000_0002, 1'b0);
        complete_run();
    end
endmodule : tb_channel_validation_trigger_select
`default_nettype wire
